// ==== include/idedec_map.svh ====
// Constants for the IDE address decoder
// Notes on behaviour
// - Primary select low when enable low and address in 1F0-1F7.
// - Alternate select low when enable low and address 3F6 or 3F7.
// - Low-byte enable on primary access, alternate reads, even alternate writes.
// - High-byte enable only for primary access while drive signals 16-bit transfer.
// - Bit 7 path on reads of primary block and even alternate address.
// - Bit 7 path on writes with primary select or even alternate address.
// - Odd alternate read keeps bit 7 path off for floppy disk-change status.
// - Odd alternate writes leave drive data transceivers high impedance.
`ifndef IDEDEC_MAP_SVH
`define IDEDEC_MAP_SVH
`define IDEDEC_ADDR_W     10
`define IDEDEC_PRI_BASE   10'h1F0
`define IDEDEC_PRI_MASK   10'h3F8
`define IDEDEC_ALT_BASE   10'h3F6
`define IDEDEC_ALT_MASK   10'h3FE
`define IDEDEC_PRI_TAG    7'h3E
`define IDEDEC_ALT_TAG    9'h1FB
`define IDEDEC_PRI_REGS   8
`define IDEDEC_ALT_REGS   2
`endif

// ==== include/idedec_pkg.sv ====
// Types for the IDE address decoder
package idedec_pkg;
   typedef enum logic [1:0] {IDEDEC_NONE, IDEDEC_PRI, IDEDEC_ALT} idedec_blk_t;
endpackage

// ==== sim/ide_address_decode_tb.sv ====
// Self-checking bench for the IDE address decoder
`timescale 1ns/1ps
`default_nettype none
module ide_address_decode_tb;
   logic       mclk = 0, rst_b = 0, aen = 1, rdB = 1, wrB = 1, wide = 0, en = 1;
   logic [9:0] addr = 10'h000;
   wire logic  iocs16_b;
   wire logic [4:0] got;
   integer     fails = 0, numChecks = 0, seed = 32'h10F8, i, r;
   logic [9:0] corner [6] = '{10'h1F0, 10'h1F7, 10'h1F8, 10'h3F6, 10'h3F7, 10'h3F5};
   idedec_drive_model drv (.wide(wide), .iocs16_b(iocs16_b));
   idedec_top dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .aen(aen), .rdStrobe_b(rdB),
      .wrStrobe_b(wrB), .iocs16_b(iocs16_b), .ideEnable(en), .primaryBlockSelect_b(got[4]),
      .alternateBlockSelect_b(got[3]), .lowByteXcvrEnable_b(got[2]),
      .highByteXcvrEnable_b(got[1]), .bit7PathEnable(got[0]));
   initial forever #25 mclk = ~mclk;
   function automatic logic [4:0] expect_out();
      logic p, a, rw;
      p = en & ~aen & (addr[9:3] == 7'h3E);
      a = en & ~aen & (addr[9:1] == 9'h1FB);
      rw = ~rdB | ~wrB;
      return {~p, ~a, ~((p & rw) | (a & (~rdB | (~wrB & ~addr[0])))), ~(p & wide & rw),
              rw & (p | (a & ~addr[0]))};
   endfunction
   task automatic compare(input logic [4:0] exp);
      numChecks = numChecks + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("wrong value at %0t: got %b expected %b", $time, got, exp);
      end
   endtask
   task automatic apply(input logic [9:0] a, input logic e, n, w, input logic [1:0] op);
      @(negedge mclk);
      addr = a;
      en = e;
      aen = n;
      wide = w;
      rdB = ~(op == 2'h1);
      wrB = ~(op == 2'h2);
      #1 compare(expect_out());
   endtask
   task automatic testDone();
      $display("checks %0d fails %0d", numChecks, fails);
      if (fails == 0 && numChecks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #100000;
      fails = fails + 1;
      testDone();
   end
   initial begin
      repeat (6) @(negedge mclk);
      rst_b = 1;
      foreach (corner[k]) for (int op = 0; op < 3; op++) begin
         apply(corner[k], 1'b1, 1'b0, k[0], op[1:0]);
         apply(corner[k], 1'b0, 1'b0, 1'b1, op[1:0]);
      end
      $display("corner test done");
      for (i = 0; i < 300; i++) begin
         r = $random(seed);
         apply(r[10] ? r[9:0] : {r[9], 5'h1F, r[3:0]}, |r[13:12], r[14] & r[15], r[16],
               r[18:17]);
      end
      $display("random test done");
      testDone();
   end
endmodule // ide_address_decode_tb
`default_nettype wire

// ==== sim/idedec_drive_model.sv ====
// Drive-side model: signals 16-bit transfers
`timescale 1ns/1ps
`default_nettype none
module idedec_drive_model (
   input  wire logic wide,
   output logic      iocs16_b
);
   assign iocs16_b = ~wide;
endmodule // idedec_drive_model
`default_nettype wire

// ==== verilog/idedec_match.sv ====
// Address block matcher
`timescale 1ns/1ps
`default_nettype none
`include "idedec_map.svh"
module idedec_match
   import idedec_pkg::*;
(
   input  wire logic [9:0] addr,
   input  wire logic       aen,
   output var idedec_blk_t blk
);
   always_comb begin
      blk = IDEDEC_NONE;
      if (!aen && ((addr & `IDEDEC_PRI_MASK) == `IDEDEC_PRI_BASE)) begin
         blk = IDEDEC_PRI;
      end else if (!aen && ((addr & `IDEDEC_ALT_MASK) == `IDEDEC_ALT_BASE)) begin
         blk = IDEDEC_ALT;
      end
   end
endmodule // idedec_match
`default_nettype wire

// ==== verilog/idedec_top.sv ====
// IDE address decoder: chip selects and transceiver enables
`timescale 1ns/1ps
`default_nettype none
`include "idedec_map.svh"
module idedec_top
   import idedec_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic [9:0] addr,
   input  wire logic       aen,
   input  wire logic       rdStrobe_b,
   input  wire logic       wrStrobe_b,
   input  wire logic       iocs16_b,
   input  wire logic       ideEnable,
   output logic            primaryBlockSelect_b,
   output logic            alternateBlockSelect_b,
   output logic            lowByteXcvrEnable_b,
   output logic            highByteXcvrEnable_b,
   output logic            bit7PathEnable
);
   // ==========================================
   // Decode
   idedec_blk_t blk;
   logic        pri;
   logic        alt;
   logic        rd;
   logic        wr;
   logic        evenA;

   idedec_match uMatch (
      .addr (addr),
      .aen  (aen),
      .blk  (blk)
   );

   assign pri   = ideEnable && (blk == IDEDEC_PRI);
   assign alt   = ideEnable && (blk == IDEDEC_ALT);
   assign rd    = !rdStrobe_b;
   assign wr    = !wrStrobe_b;
   assign evenA = !addr[0];

   assign primaryBlockSelect_b   = !pri;
   assign alternateBlockSelect_b = !alt;
   assign lowByteXcvrEnable_b    = !((pri && (rd || wr))
                                     || (alt && (rd || (wr && evenA))));
   assign highByteXcvrEnable_b   = !(!iocs16_b && pri && (rd || wr));
   assign bit7PathEnable = (rd && (pri || (alt && evenA)))
                         || (wr && (pri || (alt && evenA)));

   // ==========================================
   // Checks
   logic        chkPri;
   logic        chkAlt;
   logic        anyStrobe;

   // Second decode by address field, kept apart from the matcher
   assign chkPri    = ideEnable && !aen && (addr[9:3] == `IDEDEC_PRI_TAG);
   assign chkAlt    = ideEnable && !aen && (addr[9:1] == `IDEDEC_ALT_TAG);
   assign anyStrobe = !rdStrobe_b || !wrStrobe_b;

   // ==========================================
   // Block selects
   AST_PRI: assert property (@(posedge mclk) disable iff (!rst_b)
      chkPri
      |-> !primaryBlockSelect_b)
      else $error("primary select missing");
   AST_PRI_ONLY: assert property (@(posedge mclk) disable iff (!rst_b)
      !primaryBlockSelect_b
      |-> chkPri)
      else $error("primary select outside its block");
   AST_ALT: assert property (@(posedge mclk) disable iff (!rst_b)
      chkAlt
      |-> !alternateBlockSelect_b)
      else $error("alternate select missing");
   AST_ALT_ONLY: assert property (@(posedge mclk) disable iff (!rst_b)
      !alternateBlockSelect_b
      |-> chkAlt)
      else $error("alternate select outside its block");
   AST_SEL_AEN: assert property (@(posedge mclk) disable iff (!rst_b)
      aen
      |-> (primaryBlockSelect_b && alternateBlockSelect_b))
      else $error("select active while address enable high");
   AST_SEL_ONE: assert property (@(posedge mclk) disable iff (!rst_b)
      !primaryBlockSelect_b
      |-> alternateBlockSelect_b)
      else $error("both selects active");
   for (genvar g = 0; g < `IDEDEC_PRI_REGS; g++) begin : gPriReg
      AST_PRI_REG: assert property (@(posedge mclk) disable iff (!rst_b)
         (ideEnable && !aen && (addr == `IDEDEC_PRI_BASE + 10'(g)))
         |-> (!primaryBlockSelect_b && alternateBlockSelect_b))
         else $error("primary register address not decoded");
   end
   for (genvar g = 0; g < `IDEDEC_ALT_REGS; g++) begin : gAltReg
      AST_ALT_REG: assert property (@(posedge mclk) disable iff (!rst_b)
         (ideEnable && !aen && (addr == `IDEDEC_ALT_BASE + 10'(g)))
         |-> (!alternateBlockSelect_b && primaryBlockSelect_b))
         else $error("alternate register address not decoded");
   end

   // ==========================================
   // Low-byte transceiver
   AST_LO: assert property (@(posedge mclk) disable iff (!rst_b)
      (!alternateBlockSelect_b && rd && wrStrobe_b)
      |-> !lowByteXcvrEnable_b)
      else $error("low byte enable missing on alternate read");
   AST_LO_PRI: assert property (@(posedge mclk) disable iff (!rst_b)
      (chkPri && anyStrobe)
      |-> !lowByteXcvrEnable_b)
      else $error("low byte enable missing on primary access");
   AST_LO_ALTWR: assert property (@(posedge mclk) disable iff (!rst_b)
      (chkAlt && wr && rdStrobe_b && !addr[0])
      |-> !lowByteXcvrEnable_b)
      else $error("low byte enable missing on even alternate write");
   AST_LO_ONLY: assert property (@(posedge mclk) disable iff (!rst_b)
      !lowByteXcvrEnable_b
      |-> (anyStrobe && (chkPri || (chkAlt && (rd || !addr[0])))))
      else $error("low byte enable outside a decoded access");
   AST_LO_IDLE: assert property (@(posedge mclk) disable iff (!rst_b)
      !anyStrobe
      |-> lowByteXcvrEnable_b)
      else $error("low byte enable without a strobe");

   // ==========================================
   // High-byte transceiver
   AST_HI: assert property (@(posedge mclk) disable iff (!rst_b)
      !highByteXcvrEnable_b
      |-> (!primaryBlockSelect_b && !iocs16_b))
      else $error("high byte enable outside primary 16-bit access");
   AST_HI_ON: assert property (@(posedge mclk) disable iff (!rst_b)
      (chkPri && !iocs16_b && anyStrobe)
      |-> !highByteXcvrEnable_b)
      else $error("high byte enable missing on primary 16-bit access");
   AST_HI_8BIT: assert property (@(posedge mclk) disable iff (!rst_b)
      iocs16_b
      |-> highByteXcvrEnable_b)
      else $error("high byte enable without 16-bit indication");
   AST_HI_ALT: assert property (@(posedge mclk) disable iff (!rst_b)
      !alternateBlockSelect_b
      |-> highByteXcvrEnable_b)
      else $error("high byte enable in alternate block");
   AST_HI_IDLE: assert property (@(posedge mclk) disable iff (!rst_b)
      !anyStrobe
      |-> highByteXcvrEnable_b)
      else $error("high byte enable without a strobe");

   // ==========================================
   // Bit 7 path
   AST_D7R: assert property (@(posedge mclk) disable iff (!rst_b)
      (!primaryBlockSelect_b && rd)
      |-> bit7PathEnable)
      else $error("bit 7 path missing on primary read");
   AST_D7R_ALT: assert property (@(posedge mclk) disable iff (!rst_b)
      (chkAlt && rd && !addr[0])
      |-> bit7PathEnable)
      else $error("bit 7 path missing on even alternate read");
   AST_D7W: assert property (@(posedge mclk) disable iff (!rst_b)
      (!alternateBlockSelect_b && wr && !addr[0])
      |-> bit7PathEnable)
      else $error("bit 7 path missing on even alternate write");
   AST_D7W_PRI: assert property (@(posedge mclk) disable iff (!rst_b)
      (chkPri && wr)
      |-> bit7PathEnable)
      else $error("bit 7 path missing on primary write");
   AST_D7_ONLY: assert property (@(posedge mclk) disable iff (!rst_b)
      bit7PathEnable
      |-> (anyStrobe && (chkPri || (chkAlt && !addr[0]))))
      else $error("bit 7 path outside a decoded access");
   AST_D7_IDLE: assert property (@(posedge mclk) disable iff (!rst_b)
      !anyStrobe
      |-> !bit7PathEnable)
      else $error("bit 7 path without a strobe");

   // ==========================================
   // Odd alternate address
   AST_ODDRD: assert property (@(posedge mclk) disable iff (!rst_b)
      (!alternateBlockSelect_b && addr[0])
      |-> !bit7PathEnable)
      else $error("bit 7 path on odd alternate address");
   AST_ODDRD_LO: assert property (@(posedge mclk) disable iff (!rst_b)
      (chkAlt && addr[0] && rd)
      |-> !lowByteXcvrEnable_b)
      else $error("low byte enable missing on odd alternate read");
   AST_ODDWR: assert property (@(posedge mclk) disable iff (!rst_b)
      (!alternateBlockSelect_b && addr[0] && wr && rdStrobe_b)
      |-> lowByteXcvrEnable_b)
      else $error("transceiver driven on odd alternate write");
   AST_ODDWR_HI: assert property (@(posedge mclk) disable iff (!rst_b)
      (chkAlt && addr[0] && wr && rdStrobe_b)
      |-> (highByteXcvrEnable_b && !bit7PathEnable))
      else $error("data path driven on odd alternate write");

   // ==========================================
   // Disabled mode
   AST_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
      !ideEnable
      |-> (primaryBlockSelect_b && alternateBlockSelect_b && lowByteXcvrEnable_b
           && highByteXcvrEnable_b && !bit7PathEnable))
      else $error("output active while disabled");

   // ==========================================
   // Coverage
   COV_PRI16: cover property (@(posedge mclk) disable iff (!rst_b) !highByteXcvrEnable_b);
   COV_ALTRD: cover property (@(posedge mclk) disable iff (!rst_b)
      !alternateBlockSelect_b && rd && addr[0]);
   COV_ALTWR: cover property (@(posedge mclk) disable iff (!rst_b)
      !alternateBlockSelect_b && wr && !addr[0]);
   COV_ODDWR: cover property (@(posedge mclk) disable iff (!rst_b)
      !alternateBlockSelect_b && wr && addr[0]);
   COV_OFF: cover property (@(posedge mclk) disable iff (!rst_b)
      !ideEnable && !aen && anyStrobe && (addr[9:3] == `IDEDEC_PRI_TAG));
endmodule // idedec_top
`default_nettype wire
